// File: core/lcr_pkg.sv
// shared constants for the link configuration register bank.
// assumes one 100 MHz core clock and an 8-bit register port.
package lcr_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] LINK_CONTROL_STATUS_ADDR = 8'h04;
	localparam logic [7:0] EQUALIZER_CONVERSION_CFG_ADDR = 8'h05;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ----------------------------------------
	// link_control_status fields
	// ----------------------------------------
	localparam int LINK_ACQUIRED_BIT = 7;
	localparam int OUTPUT_DISABLE_BIT = 6;
	localparam int TEST_PATTERN_BIT = 5;
	localparam int SLEEP_BIT = 4;
	localparam int PERIPH_SEL_MSB = 3;
	localparam int PERIPH_SEL_LSB = 2;
	localparam int REVERSE_CH_BIT = 1;
	localparam int FORWARD_CH_BIT = 0;
	localparam logic [1:0] PERIPH_I2C = 2'h0;
	localparam logic [1:0] PERIPH_UART = 2'h1;
	localparam logic OUTPUT_DISABLE_RST = 1'b0;
	localparam logic TEST_PATTERN_RST = 1'b0;
	localparam logic SLEEP_RST = 1'b0;
	localparam logic [1:0] PERIPH_SEL_RST = 2'h0;
	localparam logic REVERSE_CH_RST = 1'b1;
	localparam logic FORWARD_CH_RST = 1'b1;

	// ----------------------------------------
	// equalizer_conversion_cfg fields
	// ----------------------------------------
	localparam int METHOD_BIT = 7;
	localparam int CUTOFF_MSB = 6;
	localparam int CUTOFF_LSB = 5;
	localparam int HF_DISABLE_BIT = 4;
	localparam int GAIN_MSB = 3;
	localparam int GAIN_LSB = 0;
	localparam logic METHOD_RST = 1'b0;
	localparam logic [1:0] CUTOFF_RST = 2'h1;
	localparam logic HF_DISABLE_RST = 1'b0;
	localparam logic [3:0] GAIN_STRAP_HIGH = 4'h4;
	localparam logic [3:0] GAIN_STRAP_LOW = 4'h9;
	localparam logic [1:0] GAIN_FORBIDDEN_TOP = 2'h3;

	// ----------------------------------------
	// equalizer tables, cutoff in kHz, gain in tenths of dB
	// ----------------------------------------
	localparam logic [12:0] CUTOFF_KHZ_0 = 13'h1d4c;
	localparam logic [12:0] CUTOFF_KHZ_1 = 13'h0ea6;
	localparam logic [12:0] CUTOFF_KHZ_2 = 13'h09c4;
	localparam logic [12:0] CUTOFF_KHZ_3 = 13'h074e;

	// ----------------------------------------
	// strap capture sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		LCR_SYNC_A,
		LCR_SYNC_B,
		LCR_LOAD,
		LCR_RUN
	} lcr_strap_e;

endpackage

// File: core/lcr_regs.sv
// link configuration and equalizer register bank with strap capture.
// assumes strap and lock pins are asynchronous and a plain register port.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module lcr_regs (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic link_acquired_flag_in,
	input wire logic mode_strap_in,
	input wire logic channel_direction_strap_in,
	input wire logic equalizer_strap_in,
	output logic output_disable_out,
	output logic test_pattern_enable_out,
	output logic sleep_out,
	output logic i2c_periph_enable_out,
	output logic uart_periph_enable_out,
	output logic reverse_channel_enable_out,
	output logic forward_channel_enable_out,
	output logic send_reg_addr_out,
	output logic [1:0] highpass_cutoff_sel_out,
	output logic [12:0] cutoff_khz_out,
	output logic hf_boost_enable_out,
	output logic [3:0] boost_gain_sel_out,
	output logic [7:0] boost_gain_tenth_db_out
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic lock_s;
	logic mode_strap_s;
	logic dir_strap_s;
	logic eq_strap_s;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
		end else begin
			pin_meta_r <= {equalizer_strap_in, channel_direction_strap_in, mode_strap_in,
				link_acquired_flag_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign lock_s = pin_sync_r[0];
	assign mode_strap_s = pin_sync_r[1];
	assign dir_strap_s = pin_sync_r[2];
	assign eq_strap_s = pin_sync_r[3];

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic sleep_from_straps(input logic mode, input logic dir);
		sleep_from_straps = mode & dir;
	endfunction

	function automatic logic [12:0] cutoff_khz(input logic [1:0] sel);
		case (sel)
			2'h0: cutoff_khz = lcr_pkg::CUTOFF_KHZ_0;
			2'h1: cutoff_khz = lcr_pkg::CUTOFF_KHZ_1;
			2'h2: cutoff_khz = lcr_pkg::CUTOFF_KHZ_2;
			default: cutoff_khz = lcr_pkg::CUTOFF_KHZ_3;
		endcase
	endfunction

	function automatic logic [7:0] gain_tenths(input logic [3:0] code);
		case (code)
			4'h0: gain_tenths = 8'h15;
			4'h1: gain_tenths = 8'h1c;
			4'h2: gain_tenths = 8'h22;
			4'h3: gain_tenths = 8'h2a;
			4'h4: gain_tenths = 8'h34;
			4'h5: gain_tenths = 8'h3e;
			4'h6: gain_tenths = 8'h46;
			4'h7: gain_tenths = 8'h52;
			4'h8: gain_tenths = 8'h5e;
			4'h9: gain_tenths = 8'h6b;
			4'ha: gain_tenths = 8'h75;
			default: gain_tenths = 8'h82;
		endcase
	endfunction

	function automatic logic gain_code_legal(input logic [3:0] code);
		gain_code_legal = (code[3:2] != lcr_pkg::GAIN_FORBIDDEN_TOP);
	endfunction

	// ----------------------------------------
	// strap capture after reset release
	// ----------------------------------------
	// waits two edges so both synchroniser stages hold real pin levels
	lcr_pkg::lcr_strap_e strap_st_r;
	logic strap_load;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_st_r <= lcr_pkg::LCR_SYNC_A;
		end else begin
			case (strap_st_r)
				lcr_pkg::LCR_SYNC_A: strap_st_r <= lcr_pkg::LCR_SYNC_B;
				lcr_pkg::LCR_SYNC_B: strap_st_r <= lcr_pkg::LCR_LOAD;
				lcr_pkg::LCR_LOAD: strap_st_r <= lcr_pkg::LCR_RUN;
				default: strap_st_r <= lcr_pkg::LCR_RUN;
			endcase
		end
	end

	assign strap_load = (strap_st_r == lcr_pkg::LCR_LOAD);

	// ----------------------------------------
	// register write side
	// ----------------------------------------
	logic wr_ctl;
	logic wr_eq;
	logic rd_ctl;
	logic rd_eq;
	logic out_dis_r;
	logic pattern_r;
	logic sleep_r;
	logic [1:0] periph_r;
	logic rev_r;
	logic fwd_r;
	logic method_r;
	logic [1:0] cutoff_r;
	logic hf_dis_r;
	logic [3:0] gain_r;

	always_comb begin
		wr_ctl = 1'b0;
		wr_eq = 1'b0;
		rd_ctl = 1'b0;
		rd_eq = 1'b0;
		if (reg_addr_in == lcr_pkg::LINK_CONTROL_STATUS_ADDR) begin
			wr_ctl = reg_wr_in;
			rd_ctl = reg_rd_in;
		end else if (reg_addr_in == lcr_pkg::EQUALIZER_CONVERSION_CFG_ADDR) begin
			wr_eq = reg_wr_in;
			rd_eq = reg_rd_in;
		end
	end

	// bit 7 of the control register has no storage, writes to it vanish
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_dis_r <= lcr_pkg::OUTPUT_DISABLE_RST;
			pattern_r <= lcr_pkg::TEST_PATTERN_RST;
			periph_r <= lcr_pkg::PERIPH_SEL_RST;
			rev_r <= lcr_pkg::REVERSE_CH_RST;
			fwd_r <= lcr_pkg::FORWARD_CH_RST;
		end else if (wr_ctl) begin
			out_dis_r <= reg_wdata_in[lcr_pkg::OUTPUT_DISABLE_BIT];
			pattern_r <= reg_wdata_in[lcr_pkg::TEST_PATTERN_BIT];
			periph_r <= reg_wdata_in[lcr_pkg::PERIPH_SEL_MSB:lcr_pkg::PERIPH_SEL_LSB];
			rev_r <= reg_wdata_in[lcr_pkg::REVERSE_CH_BIT];
			fwd_r <= reg_wdata_in[lcr_pkg::FORWARD_CH_BIT];
		end
	end

	// software write wins over the strap load in the same cycle
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sleep_r <= lcr_pkg::SLEEP_RST;
		end else if (wr_ctl) begin
			sleep_r <= reg_wdata_in[lcr_pkg::SLEEP_BIT];
		end else if (strap_load) begin
			sleep_r <= sleep_from_straps(mode_strap_s, dir_strap_s);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			method_r <= lcr_pkg::METHOD_RST;
			cutoff_r <= lcr_pkg::CUTOFF_RST;
			hf_dis_r <= lcr_pkg::HF_DISABLE_RST;
		end else if (wr_eq) begin
			method_r <= reg_wdata_in[lcr_pkg::METHOD_BIT];
			cutoff_r <= reg_wdata_in[lcr_pkg::CUTOFF_MSB:lcr_pkg::CUTOFF_LSB];
			hf_dis_r <= reg_wdata_in[lcr_pkg::HF_DISABLE_BIT];
		end
	end

	// forbidden gain codes are dropped so the equalizer never sees them
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gain_r <= lcr_pkg::GAIN_STRAP_HIGH;
		end else if (wr_eq &&
			gain_code_legal(reg_wdata_in[lcr_pkg::GAIN_MSB:lcr_pkg::GAIN_LSB])) begin
			gain_r <= reg_wdata_in[lcr_pkg::GAIN_MSB:lcr_pkg::GAIN_LSB];
		end else if (strap_load) begin
			// a refused gain write leaves the strap load in force
			gain_r <= eq_strap_s ? lcr_pkg::GAIN_STRAP_HIGH : lcr_pkg::GAIN_STRAP_LOW;
		end
	end

	// ----------------------------------------
	// read side
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= lcr_pkg::UNMAPPED_READ_VALUE;
		end else if (rd_ctl) begin
			reg_rdata_out <= {lock_s, out_dis_r, pattern_r, sleep_r, periph_r, rev_r, fwd_r};
		end else if (rd_eq) begin
			reg_rdata_out <= {method_r, cutoff_r, hf_dis_r, gain_r};
		end else begin
			reg_rdata_out <= lcr_pkg::UNMAPPED_READ_VALUE;
		end
	end

	// ----------------------------------------
	// decoded control outputs
	// ----------------------------------------
	// decoded outputs lag the register by one cycle, kept glitch free
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			i2c_periph_enable_out <= 1'b0;
			uart_periph_enable_out <= 1'b0;
			send_reg_addr_out <= 1'b0;
			hf_boost_enable_out <= 1'b0;
			cutoff_khz_out <= 13'h0000;
			boost_gain_tenth_db_out <= 8'h00;
		end else begin
			i2c_periph_enable_out <= (periph_r == lcr_pkg::PERIPH_I2C);
			uart_periph_enable_out <= (periph_r == lcr_pkg::PERIPH_UART);
			send_reg_addr_out <= !method_r;
			hf_boost_enable_out <= !hf_dis_r;
			cutoff_khz_out <= cutoff_khz(cutoff_r);
			boost_gain_tenth_db_out <= gain_tenths(gain_r);
		end
	end

	assign output_disable_out = out_dis_r;
	assign test_pattern_enable_out = pattern_r;
	assign sleep_out = sleep_r;
	assign reverse_channel_enable_out = rev_r;
	assign forward_channel_enable_out = fwd_r;
	assign highpass_cutoff_sel_out = cutoff_r;
	assign boost_gain_sel_out = gain_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sleep_strap_a: assert property (strap_load && !wr_ctl
		|=> sleep_r == $past(mode_strap_s & dir_strap_s))
		else $error("sleep not loaded from straps");
	uart_sel_a: assert property (wr_ctl && reg_wdata_in[3:2] == 2'h1
		|=> ##1 uart_periph_enable_out && !i2c_periph_enable_out)
		else $error("uart select not decoded");
	periph_off_a: assert property (periph_r[1]
		|=> !i2c_periph_enable_out && !uart_periph_enable_out)
		else $error("peripheral not disabled");
	chan_reset_a: assert property (strap_st_r == lcr_pkg::LCR_SYNC_A
		|-> rev_r && fwd_r && !out_dis_r && !pattern_r)
		else $error("channel reset values wrong");
	chan_write_a: assert property (wr_ctl
		|=> rev_r == $past(reg_wdata_in[1]) && fwd_r == $past(reg_wdata_in[0]))
		else $error("channel enables not written");
	eq_readback_a: assert property (rd_eq
		|=> reg_rdata_out == {$past(method_r), $past(cutoff_r), $past(hf_dis_r), $past(gain_r)})
		else $error("equalizer readback wrong");
	cutoff_map_a: assert property (cutoff_r == 2'h3 && $stable(cutoff_r)
		|-> cutoff_khz_out == lcr_pkg::CUTOFF_KHZ_3)
		else $error("cutoff decode wrong");
	eq_reset_a: assert property (strap_st_r == lcr_pkg::LCR_SYNC_A
		|-> cutoff_r == lcr_pkg::CUTOFF_RST && !method_r && !hf_dis_r)
		else $error("equalizer reset values wrong");
	// decoded flops still sit in reset at the release edge, so skip that cycle
	hf_boost_a: assert property ($past(rst_n_in)
		|-> hf_boost_enable_out == !$past(hf_dis_r))
		else $error("boost enable inverted wrong");
	gain_reject_a: assert property (wr_eq && reg_wdata_in[3:2] == 2'h3 && !strap_load
		|=> $stable(gain_r))
		else $error("forbidden gain accepted");
	gain_strap_a: assert property (strap_load && !wr_eq
		|=> gain_r == ($past(eq_strap_s) ? lcr_pkg::GAIN_STRAP_HIGH : lcr_pkg::GAIN_STRAP_LOW))
		else $error("gain strap load wrong");
	lock_mirror_a: assert property (rd_ctl
		|=> reg_rdata_out[7] == $past(lock_s) && reg_rdata_out[6] == $past(out_dis_r))
		else $error("lock mirror wrong");

	gain_write_c: cover property (wr_eq ##1 rd_eq ##1 reg_rdata_out[3:0] == gain_r);
	lock_read_c: cover property (rd_ctl && lock_s);
	uart_mode_c: cover property (uart_periph_enable_out);
	sleep_on_c: cover property (sleep_r ##1 !sleep_r);

endmodule

// File: tb/lcr_pins_model.sv
// board-side model of the lock and strap pins facing the register bank.
// assumes the bench changes strap levels only while the bank is in reset.
`timescale 1ns/1ps
module lcr_pins_model (
	input wire logic [2:0] strap_cfg_in,
	input wire logic lock_in,
	output logic mode_strap_out,
	output logic channel_direction_strap_out,
	output logic equalizer_strap_out,
	output logic link_acquired_flag_out
);
	// straps are plain resistors, static while powered
	assign mode_strap_out = strap_cfg_in[2];
	assign channel_direction_strap_out = strap_cfg_in[1];
	assign equalizer_strap_out = strap_cfg_in[0];
	// lock is asynchronous to the core clock, so it moves off the edge
	initial link_acquired_flag_out = 1'b0;
	always @(lock_in) begin
		link_acquired_flag_out <= #3 lock_in;
	end
endmodule

// File: tb/link_config_registers_test.sv
// self-checking bench for the link configuration register bank.
// assumes lcr_pkg is compiled first and the pin model drives straps and lock.
`timescale 1ns/1ps
module link_config_registers_test;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] straps = 3'b110;
	logic lock = 1'b0;
	int failures = 0;
	int checks_done = 0;
	logic [7:0] rdata, gtenth;
	logic mode_pin, dir_pin, eq_pin, lk, od, tp, slp, i2c, uart, rev, fwd, sra, hfb;
	logic [1:0] hp;
	logic [12:0] khz;
	logic [3:0] gain;
	logic [7:0] gt [12] = '{8'h15, 8'h1c, 8'h22, 8'h2a, 8'h34, 8'h3e,
		8'h46, 8'h52, 8'h5e, 8'h6b, 8'h75, 8'h82};
	logic [12:0] ct [4] = '{lcr_pkg::CUTOFF_KHZ_0, lcr_pkg::CUTOFF_KHZ_1,
		lcr_pkg::CUTOFF_KHZ_2, lcr_pkg::CUTOFF_KHZ_3};

	always #5 core_clk_in = ~core_clk_in;

	lcr_pins_model lcr_pins_model_i (.strap_cfg_in(straps), .lock_in(lock),
		.mode_strap_out(mode_pin), .channel_direction_strap_out(dir_pin),
		.equalizer_strap_out(eq_pin), .link_acquired_flag_out(lk));

	lcr_regs lcr_regs_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .link_acquired_flag_in(lk), .mode_strap_in(mode_pin),
		.channel_direction_strap_in(dir_pin), .equalizer_strap_in(eq_pin),
		.output_disable_out(od), .test_pattern_enable_out(tp), .sleep_out(slp),
		.i2c_periph_enable_out(i2c), .uart_periph_enable_out(uart),
		.reverse_channel_enable_out(rev), .forward_channel_enable_out(fwd),
		.send_reg_addr_out(sra), .highpass_cutoff_sel_out(hp),
		.cutoff_khz_out(khz), .hf_boost_enable_out(hfb),
		.boost_gain_sel_out(gain), .boost_gain_tenth_db_out(gtenth));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// returns 1 ns after the edge on which the decoded outputs settle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_in);
		wr <= 1'b0;
		@(posedge core_clk_in);
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset(input logic [2:0] s);
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		straps <= s;
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset(input logic [2:0] s);
		logic [7:0] d;
		do_reset(s);
		rd_reg(8'h04, d);
		chk(d, {3'b000, s[2] & s[1], 4'b0011}, "ctl reset");
		chk({od, tp, i2c, uart, rev, fwd}, 6'b001011, "ctl outs");
		rd_reg(8'h05, d);
		chk(d, {4'b0010, s[0] ? 4'h4 : 4'h9}, "eq reset");
		chk(khz, ct[1], "cutoff reset");
		chk(hp, 2'h1, "cutoff sel reset");
		chk({sra, hfb, slp}, {2'b11, s[2] & s[1]}, "eq outs");
		chk(gtenth, s[0] ? gt[4] : gt[9], "gain reset");
		$display("test reset straps %b done", s);
	endtask

	task automatic t_ctl();
		logic [7:0] d;
		wr_reg(8'h04, 8'hff);
		rd_reg(8'h04, d);
		chk(d, 8'h7f, "ctl readback");
		chk({od, tp, slp, i2c, uart, rev, fwd}, 7'b1110011, "ctl all set");
		@(posedge core_clk_in);
		#1 chk(rdata, 8'h00, "rdata idle");
		for (int p = 0; p < 4; p++) begin
			wr_reg(8'h04, {4'b0000, p[1:0], 2'b00});
			chk({i2c, uart}, {p == 0, p == 1}, "periph sel");
			chk({od, tp, slp, rev, fwd}, 5'b00000, "ctl clear");
		end
		$display("test control done");
	endtask

	task automatic t_eq();
		logic [7:0] d;
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h05, {c[0], c[1:0], c[1], 4'h0});
			chk({sra, hfb}, {~c[0], ~c[1]}, "method hf");
			chk(khz, ct[c], "cutoff");
			chk(hp, c[1:0], "cutoff sel");
			rd_reg(8'h05, d);
			chk(d, {c[0], c[1:0], c[1], 4'h0}, "eq readback");
		end
		for (int g = 0; g < 12; g++) begin
			wr_reg(8'h05, {4'b0010, g[3:0]});
			chk({gain, gtenth}, {g[3:0], gt[g]}, "gain code");
		end
		wr_reg(8'h05, 8'h6e);
		rd_reg(8'h05, d);
		chk(d, 8'h6b, "forbidden gain");
		$display("test equalizer done");
	endtask

	task automatic t_misc();
		logic [7:0] d;
		wr_reg(8'h06, 8'h33);
		rd_reg(8'h06, d);
		chk(d, 8'h00, "unmapped read");
		lock <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		wr_reg(8'h04, 8'h00);
		rd_reg(8'h04, d);
		chk(d, 8'h80, "lock mirror");
		lock <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		rd_reg(8'h04, d);
		chk(d, 8'h00, "lock drop");
		$display("test misc done");
	endtask

	initial begin
		repeat (20000) @(posedge core_clk_in);
		failures++;
		print_verdict();
	end

	initial begin
		t_reset(3'b110);
		t_ctl();
		t_eq();
		t_misc();
		t_reset(3'b001);
		print_verdict();
	end
endmodule
